// ---- popc_pkg.sv ----
// package: command codes, reset values, field positions, timing, types
package popc_pkg;

	// ----------
	// command codes
	// ----------
	localparam logic [7:0] CMD_PAGE      = 8'h00; // channel page select
	localparam logic [7:0] CMD_OPER_MODE = 8'h01; // operating_mode
	localparam logic [7:0] CMD_ONOFF_CFG = 8'h02; // on_off_source_config
	localparam logic [7:0] CMD_SW_FREQ   = 8'h33; // switching_frequency
	localparam logic [7:0] CMD_LOOP_COMP = 8'hD3; // loop_compensation
	localparam logic [7:0] CMD_CONV_MODE = 8'hD4; // converter_mode
	localparam logic [7:0] CMD_PHASE_CFG = 8'hF5; // phase_and_sense_config
	localparam logic [7:0] CMD_BUS_RESET = 8'hFD; // bus_reset_command

	// data byte counts per command kind
	localparam logic [1:0] NB_SEND = 2'h0; // no data bytes
	localparam logic [1:0] NB_BYTE = 2'h1; // one data byte
	localparam logic [1:0] NB_WORD = 2'h2; // two data bytes

	// ----------
	// reset values of the working registers
	// ----------
	localparam logic [15:0] RST_SW_FREQ   = 16'hFB52;
	localparam logic [7:0]  RST_LOOP_COMP = 8'hAE;
	localparam logic [7:0]  RST_CONV_MODE = 8'hC7;
	localparam logic [7:0]  RST_PHASE_CFG = 8'h10;
	localparam logic [7:0]  RST_ONOFF_CFG = 8'h1E;
	localparam logic [7:0]  RST_OPER_MODE = 8'h40; // sequenced off
	localparam logic [7:0]  RST_PAGE      = 8'h00;

	// ----------
	// supported codes
	// ----------
	localparam logic [7:0] ONOFF_BOTH_IMM = 8'h1F;
	localparam logic [7:0] ONOFF_BOTH_SEQ = 8'h1E;
	localparam logic [7:0] ONOFF_PIN_IMM  = 8'h17;
	localparam logic [7:0] ONOFF_PIN_SEQ  = 8'h16;
	localparam logic [7:0] OP_MARGIN_HI   = 8'hA8;
	localparam logic [7:0] OP_MARGIN_LO   = 8'h98;
	localparam logic [7:0] OP_ON          = 8'h80;
	localparam logic [7:0] OP_SOFT_OFF    = 8'h40;
	localparam logic [7:0] OP_IMM_OFF     = 8'h00;
	localparam logic [7:0] PAGE_CH0       = 8'h00;
	localparam logic [7:0] PAGE_CH1       = 8'h01;
	localparam logic [7:0] PAGE_ALL       = 8'hFF;

	// ----------
	// field positions
	// ----------
	localparam int ONOFF_OPCTL_BIT = 3; // bus on/off control enabled
	localparam int ONOFF_IMM_BIT   = 0; // immediate off on off request
	localparam int OP_ON_BIT       = 7; // mode requests running
	localparam int MODE_ILIM_BIT   = 7;
	localparam int MODE_SERVO_BIT  = 6;
	localparam int MODE_TEMP_BIT   = 5;
	localparam int MODE_LOWDCR_BIT = 2;
	localparam int MODE_VRNG_BIT   = 1;
	localparam int MODE_FCCM_BIT   = 0;
	localparam int COMP_GM_MSB     = 7;
	localparam int COMP_GM_LSB     = 5;
	localparam int COMP_COMPENSATION_RESISTOR_MSB   = 4;
	localparam int COMP_COMPENSATION_RESISTOR_LSB   = 0;

	// abstract set-point codes for the reference converter
	localparam logic [7:0] SP_ZERO = 8'h00;
	localparam logic [7:0] SP_NOM  = 8'h80;
	localparam logic [7:0] SP_HI   = 8'h88;
	localparam logic [7:0] SP_LO   = 8'h78;

	// ----------
	// timing
	// ----------
	localparam int CLK_PERIOD_NS = 25;
	localparam int TON_RISE_NS   = 5000; // soft-start ramp time
	localparam int TOFF_DLY_NS   = 2000; // turn-off delay
	localparam int TOFF_FALL_NS  = 5000; // turn-off fall time
	localparam int TRANS_STEP_NS = 250;  // time per set-point step
	localparam logic [15:0] TON_RISE_CYC = 16'(
		(TON_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] TOFF_DLY_CYC = 16'(
		(TOFF_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] TOFF_FALL_CYC = 16'(
		(TOFF_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] TRANS_STEP_CYC = 16'(
		(TRANS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------
	// types
	// ----------
	typedef enum logic [4:0] {
		ST_OFF       = 5'b00001,
		ST_RISE      = 5'b00010,
		ST_ON        = 5'b00100,
		ST_TOFF_DLY  = 5'b01000,
		ST_TOFF_FALL = 5'b10000
	} popc_state_t;

	typedef struct packed {
		logic [7:0] onoff;  // on_off_source_config
		logic [7:0] opmode; // operating_mode
		logic [7:0] mode;   // converter_mode
		logic [7:0] comp;   // loop_compensation
	} popc_chan_cfg_t;

	typedef struct packed {
		popc_chan_cfg_t [1:0] ch;    // per-channel image
		logic [7:0]           phase; // phase_and_sense_config
		logic [15:0]          freq;  // switching_frequency
	} popc_nvm_t;

	typedef struct packed {
		logic       run;         // channel switching
		logic       ramping;     // ramping on or off
		logic       servo_en;    // set-point trim active
		logic       fccm;        // forced continuous conduction
		logic       ilim_high;   // high current-limit range
		logic       vrange_low;  // 2.75V output range
		logic       temp_direct; // direct sense-pin voltage
		logic       low_dcr;     // ultra-low resistance sensing
		logic [2:0] gm;          // error amplifier step
		logic [4:0] compensation_resistor;        // compensation_resistor step
		logic [7:0] setpoint;    // reference converter code
	} popc_chan_out_t;

endpackage

// ---- popc_sync.sv ----
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module popc_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q; // first stage, read only by second stage

	// ----------
	// two stages
	// ----------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ---- popc_chan.sv ----
// one channel on/off sequencer with set-point slope control
`timescale 1ns/1ps
module popc_chan
	import popc_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic         run_req_i,   // pin requests run, and mode too when bus control is on
	input  wire logic         off_imm_i,   // off request is immediate
	input  wire logic         force_off_i, // bus reset: stop now
	input  wire logic [7:0]   target_i,    // margined or nominal code
	output popc_state_t       state_o,
	output logic      [7:0]   setpoint_o
);
	popc_state_t st_d;      // next state
	logic [15:0] tmr_q;     // sequencing timer
	logic [15:0] tmr_d;
	logic [15:0] step_q;    // slope step timer
	logic [15:0] step_d;
	logic [7:0]  sp_d;

	// ----------
	// next-state logic
	// ----------
	always_comb begin
		st_d   = state_o;
		tmr_d  = tmr_q;
		step_d = step_q;
		sp_d   = setpoint_o;
		case (state_o)
			ST_OFF: begin
				sp_d = SP_ZERO;
				if (run_req_i && !force_off_i) begin
					st_d  = ST_RISE;
					tmr_d = TON_RISE_CYC - 16'h0001;
				end
			end
			ST_RISE: begin
				if (force_off_i || !run_req_i) begin
					st_d = ST_OFF; // abort start
				end else if (tmr_q == 16'h0000) begin
					st_d   = ST_ON;
					sp_d   = SP_NOM;
					step_d = TRANS_STEP_CYC - 16'h0001;
				end else begin
					tmr_d = tmr_q - 16'h0001;
				end
			end
			ST_ON: begin
				if (force_off_i || (!run_req_i && off_imm_i)) begin
					st_d = ST_OFF; // [R1] [R3] [R11] [R13]
				end else if (!run_req_i) begin
					st_d  = ST_TOFF_DLY; // [R2] [R4] [R11]
					tmr_d = TOFF_DLY_CYC - 16'h0001;
				end else if (step_q != 16'h0000) begin
					step_d = step_q - 16'h0001;
				end else begin
					// one code per step period, never a jump [R8] [R7]
					step_d = TRANS_STEP_CYC - 16'h0001;
					if (setpoint_o < target_i) begin
						sp_d = setpoint_o + 8'h01;
					end else if (setpoint_o > target_i) begin
						sp_d = setpoint_o - 8'h01;
					end
				end
			end
			ST_TOFF_DLY: begin
				if (force_off_i || off_imm_i) begin
					st_d = ST_OFF;
				end else if (tmr_q == 16'h0000) begin
					st_d  = ST_TOFF_FALL; // [R2] [R4]
					tmr_d = TOFF_FALL_CYC - 16'h0001;
				end else begin
					tmr_d = tmr_q - 16'h0001;
				end
			end
			ST_TOFF_FALL: begin
				if (force_off_i || off_imm_i || tmr_q == 16'h0000) begin
					st_d = ST_OFF;
				end else begin
					tmr_d = tmr_q - 16'h0001;
				end
			end
			default: begin
				st_d = ST_OFF;
			end
		endcase
	end

	// ----------
	// state registers
	// ----------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_o    <= ST_OFF; // [R9]
			tmr_q      <= 16'h0000;
			step_q     <= 16'h0000;
			setpoint_o <= SP_ZERO;
		end else begin
			state_o    <= st_d;
			tmr_q      <= tmr_d;
			step_q     <= step_d;
			setpoint_o <= sp_d;
		end
	end
endmodule

// ---- popc_top.sv ----
// command register bank, on/off decision and converter settings
// Functional notes
// R1 - 0x1F: both sources run, immediate off
// R2 - 0x1E: both sources run, sequenced off
// R3 - 0x17: pin only, immediate off
// R4 - 0x16: pin only, sequenced off
// R5 - unlisted config or mode codes: ignore, fault
// R6 - mode held until new write or pin
// R7 - stored margin mode ramps after reset
// R8 - mode change moves set point by slope
// R9 - reset leaves channels sequenced off
// R10 - decode margin high, low and on
// R11 - decode soft off and immediate off
// R12 - off codes ignored when config bit3 clear
// R13 - bus reset: off, reload, clear, restart
// R14 - mode bit7 current range, locked while active
// R15 - mode bit1 voltage range, locked while active
// R16 - servo trim only while steadily on
// R17 - mode bit5 selects temperature method
// R18 - mode bit2 ultra-low resistance sensing
// R19 - bit0 continuous conduction, never while rising
// R20 - comp bits 7:5 amplifier step
// R21 - comp bits 4:0 resistor step
// R22 - phase or frequency write busy: nack
// R23 - paged registers per channel, two shared
`timescale 1ns/1ps
module popc_top
	import popc_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [1:0]           channel_enable_pin_i,
	input  wire popc_pkg::popc_nvm_t  nvm_i,
	input  wire logic                 cmd_valid_i,
	input  wire logic                 cmd_write_i,
	input  wire logic [7:0]           cmd_code_i,
	input  wire logic [1:0]           cmd_nbytes_i,
	input  wire logic [15:0]          cmd_data_i,
	output logic                      resp_valid_o,
	output logic                      resp_ack_o,
	output logic [15:0]               resp_data_o,
	output logic                      cml_fault_o,
	output logic                      busy_fault_o,
	output popc_pkg::popc_chan_out_t [1:0] chan_o,
	output logic [7:0]                phase_cfg_o,
	output logic [15:0]               sw_freq_o
);
	import popc_pkg::*;

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	popc_chan_cfg_t [1:0] cfg_q;   // paged registers
	popc_chan_cfg_t [1:0] cfg_d;
	logic [7:0]           page_q;  // page select
	logic [7:0]           phase_q; // shared phase config
	logic [15:0]          freq_q;  // shared frequency
	logic                 load_q;  // power-on load pending
	logic                 force_q; // bus reset force-off pulse
	logic [1:0]           pin_s;   // synchronised run pins
	popc_state_t          st [2];  // channel states
	logic [7:0]           sp [2];  // channel set points

	// ------------------------------------------------------------------
	// run pin synchroniser
	// ------------------------------------------------------------------
	popc_sync #(
		.W(2)
	) u_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.async_i (channel_enable_pin_i),
		.sync_o  (pin_s)
	);

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	wire wr      = cmd_valid_i & cmd_write_i;
	wire rd      = cmd_valid_i & ~cmd_write_i;
	wire hit_pg  = cmd_code_i == CMD_PAGE;
	wire hit_op  = cmd_code_i == CMD_OPER_MODE;
	wire hit_oo  = cmd_code_i == CMD_ONOFF_CFG;
	wire hit_fq  = cmd_code_i == CMD_SW_FREQ;
	wire hit_cp  = cmd_code_i == CMD_LOOP_COMP;
	wire hit_md  = cmd_code_i == CMD_CONV_MODE;
	wire hit_ph  = cmd_code_i == CMD_PHASE_CFG;
	wire hit_rs  = cmd_code_i == CMD_BUS_RESET;
	wire hit_b   = hit_pg | hit_op | hit_oo | hit_cp | hit_md | hit_ph;
	// bus reset is write-only with no data [R13]
	wire known   = hit_b | hit_fq | (hit_rs & cmd_write_i);
	wire [1:0] nb_need = hit_fq ? NB_WORD : (hit_rs ? NB_SEND : NB_BYTE);
	wire len_ok  = ~cmd_write_i | (cmd_nbytes_i == nb_need);
	wire [7:0] wb = cmd_data_i[7:0]; // byte payload

	// pages: 0x00 and 0x01 pick one channel, 0xFF writes both [R23]
	wire sel0    = (page_q == PAGE_CH0) | (page_q == PAGE_ALL);
	wire sel1    = (page_q == PAGE_CH1) | (page_q == PAGE_ALL);
	wire [1:0] sel = {sel1, sel0};
	wire rdch    = page_q == PAGE_CH1; // reads of page 0xFF show ch 0
	wire page_ok = (wb == PAGE_CH0) | (wb == PAGE_CH1) | (wb == PAGE_ALL);

	// supported code checks [R5] [R10] [R11]
	wire oo_ok   = (wb == ONOFF_BOTH_IMM) | (wb == ONOFF_BOTH_SEQ) |
	               (wb == ONOFF_PIN_IMM) | (wb == ONOFF_PIN_SEQ);
	wire op_ok   = (wb == OP_MARGIN_HI) | (wb == OP_MARGIN_LO) |
	               (wb == OP_ON) | (wb == OP_SOFT_OFF) | (wb == OP_IMM_OFF);
	wire op_offc = (wb == OP_SOFT_OFF) | (wb == OP_IMM_OFF);

	// channel activity seen by the write checks
	wire [1:0] active = {st[1] != ST_OFF, st[0] != ST_OFF};
	wire any_run = |active;

	// range bits may not change on an active channel [R14] [R15]
	wire [1:0] md_lock;
	assign md_lock[0] = sel[0] & active[0] &
		((wb[MODE_ILIM_BIT] ^ cfg_q[0].mode[MODE_ILIM_BIT]) |
		 (wb[MODE_VRNG_BIT] ^ cfg_q[0].mode[MODE_VRNG_BIT]));
	assign md_lock[1] = sel[1] & active[1] &
		((wb[MODE_ILIM_BIT] ^ cfg_q[1].mode[MODE_ILIM_BIT]) |
		 (wb[MODE_VRNG_BIT] ^ cfg_q[1].mode[MODE_VRNG_BIT]));

	// shared timing registers refuse writes while running [R22]
	wire busy_ev = wr & len_ok & (hit_ph | hit_fq) & any_run;

	// a good write of each kind
	wire w_ok    = wr & len_ok;
	wire w_pg    = w_ok & hit_pg & page_ok;
	wire w_oo    = w_ok & hit_oo & oo_ok;
	wire w_op    = w_ok & hit_op & op_ok;
	wire w_md    = w_ok & hit_md & ~(|md_lock);
	wire w_cp    = w_ok & hit_cp;
	wire w_ph    = w_ok & hit_ph & ~any_run;
	wire w_fq    = w_ok & hit_fq & ~any_run;
	wire w_rs    = w_ok & hit_rs;

	// communication fault causes [R5] [R14] [R15]
	wire cml_ev  = cmd_valid_i & (~known | ~len_ok |
		(cmd_write_i & hit_pg & ~page_ok) |
		(cmd_write_i & hit_oo & ~oo_ok) |
		(cmd_write_i & hit_op & ~op_ok) |
		(cmd_write_i & hit_md & (|md_lock)));
	wire nack    = ~known | busy_ev; // [R22]

	// read data selection
	wire [15:0] rd_data =
		hit_pg ? {8'h00, page_q} :
		hit_op ? {8'h00, cfg_q[rdch].opmode} :
		hit_oo ? {8'h00, cfg_q[rdch].onoff} :
		hit_md ? {8'h00, cfg_q[rdch].mode} :
		hit_cp ? {8'h00, cfg_q[rdch].comp} :
		hit_ph ? {8'h00, phase_q} :
		hit_fq ? freq_q : 16'h0000;

	// ------------------------------------------------------------------
	// next value of the paged registers
	// ------------------------------------------------------------------
	always_comb begin
		cfg_d = cfg_q;
		for (int c = 0; c < 2; c++) begin
			if (sel[c] && w_oo) begin
				cfg_d[c].onoff = wb; // bad codes never land [R5]
			end
			// off codes are ignored without bus control [R12]
			if (sel[c] && w_op &&
			    !(op_offc && !cfg_q[c].onoff[ONOFF_OPCTL_BIT])) begin
				cfg_d[c].opmode = wb; // held until rewritten [R6]
			end
			if (sel[c] && w_md) begin
				cfg_d[c].mode = wb; // [R14] [R15] [R18]
			end
			if (sel[c] && w_cp) begin
				cfg_d[c].comp = wb;
			end
		end
	end

	// ------------------------------------------------------------------
	// register update, power-on load and bus reset reload
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int c = 0; c < 2; c++) begin
				cfg_q[c].onoff  <= RST_ONOFF_CFG;
				cfg_q[c].opmode <= RST_OPER_MODE; // [R9]
				cfg_q[c].mode   <= RST_CONV_MODE;
				cfg_q[c].comp   <= RST_LOOP_COMP;
			end
			phase_q <= RST_PHASE_CFG;
			freq_q  <= RST_SW_FREQ;
			page_q  <= RST_PAGE;
			load_q  <= 1'b1;
		end else if (load_q || w_rs) begin
			// stored image, margin modes included [R7] [R13]
			cfg_q   <= nvm_i.ch;
			phase_q <= nvm_i.phase;
			freq_q  <= nvm_i.freq;
			page_q  <= RST_PAGE;
			load_q  <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			if (w_pg) begin
				page_q <= wb;
			end
			if (w_ph) begin
				phase_q <= wb; // [R22]
			end
			if (w_fq) begin
				freq_q <= cmd_data_i; // [R22]
			end
		end
	end

	// ------------------------------------------------------------------
	// sticky faults and bus reset pulse
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cml_fault_o  <= 1'b0;
			busy_fault_o <= 1'b0;
			force_q      <= 1'b0;
		end else begin
			// bus reset clears all faults [R13]
			cml_fault_o  <= cml_ev | (cml_fault_o & ~w_rs); // [R5]
			busy_fault_o <= busy_ev | (busy_fault_o & ~w_rs); // [R22]
			force_q      <= w_rs; // both channels off at once [R13]
		end
	end

	// ------------------------------------------------------------------
	// response to each command, one cycle later
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			resp_valid_o <= 1'b0;
			resp_ack_o   <= 1'b0;
			resp_data_o  <= 16'h0000;
		end else begin
			resp_valid_o <= cmd_valid_i;
			resp_ack_o   <= cmd_valid_i & ~nack;
			resp_data_o  <= (rd & known) ? rd_data : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// per-channel on/off decision and sequencers
	// ------------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_ch
		// bus control enabled: needs mode and pin [R1] [R2]
		// bus control disabled: pin alone [R3] [R4]
		wire opctl   = cfg_q[c].onoff[ONOFF_OPCTL_BIT];
		wire op_run  = cfg_q[c].opmode[OP_ON_BIT];
		wire run_req = pin_s[c] & (~opctl | op_run);
		// a bus-commanded off picks its own style [R11]
		wire op_imm  = opctl & (cfg_q[c].opmode == OP_IMM_OFF);
		wire op_soft = opctl & (cfg_q[c].opmode == OP_SOFT_OFF);
		wire off_imm = op_imm |
			(cfg_q[c].onoff[ONOFF_IMM_BIT] & ~(op_soft & pin_s[c]));
		// margin codes steer the target; 0x80 is nominal [R10]
		wire [7:0] tgt =
			(cfg_q[c].opmode == OP_MARGIN_HI) ? SP_HI :
			(cfg_q[c].opmode == OP_MARGIN_LO) ? SP_LO : SP_NOM;

		popc_chan u_chan (
			.clk_i       (clk_i),
			.rstn_i      (rstn_i),
			.run_req_i   (run_req),
			.off_imm_i   (off_imm),
			.force_off_i (force_q),
			.target_i    (tgt),
			.state_o     (st[c]),
			.setpoint_o  (sp[c])
		);
	end

	// ------------------------------------------------------------------
	// registered channel outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			chan_o      <= '0;
			phase_cfg_o <= RST_PHASE_CFG;
			sw_freq_o   <= RST_SW_FREQ;
		end else begin
			for (int c = 0; c < 2; c++) begin
				chan_o[c].run         <= st[c] != ST_OFF;
				chan_o[c].ramping     <= (st[c] == ST_RISE) |
				                         (st[c] == ST_TOFF_FALL);
				// trim only when steadily on [R16]
				chan_o[c].servo_en    <= cfg_q[c].mode[MODE_SERVO_BIT] &
				                         (st[c] == ST_ON);
				// discontinuous while rising [R19]
				chan_o[c].fccm        <= cfg_q[c].mode[MODE_FCCM_BIT] &
				                         (st[c] != ST_RISE);
				chan_o[c].ilim_high   <= cfg_q[c].mode[MODE_ILIM_BIT];
				chan_o[c].vrange_low  <= cfg_q[c].mode[MODE_VRNG_BIT];
				chan_o[c].temp_direct <= cfg_q[c].mode[MODE_TEMP_BIT]; // [R17]
				chan_o[c].low_dcr     <= cfg_q[c].mode[MODE_LOWDCR_BIT];
				chan_o[c].gm          <=
					cfg_q[c].comp[COMP_GM_MSB:COMP_GM_LSB]; // [R20]
				chan_o[c].compensation_resistor        <=
					cfg_q[c].comp[COMP_COMPENSATION_RESISTOR_MSB:COMP_COMPENSATION_RESISTOR_LSB]; // [R21]
				chan_o[c].setpoint    <= sp[c]; // [R8]
			end
			phase_cfg_o <= phase_q;
			sw_freq_o   <= freq_q;
		end
	end
endmodule

// ---- popc_top_asserts.sv ----
// checker: command port and channel output assertions
`timescale 1ns/1ps
module popc_top_asserts
	import popc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        cmd_valid_i,
	input wire logic        cmd_write_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [1:0]  cmd_nbytes_i,
	input wire logic [15:0] cmd_data_i,
	input wire logic        resp_valid_o,
	input wire logic        resp_ack_o,
	input wire logic        cml_fault_o,
	input wire logic        busy_fault_o,
	input wire popc_pkg::popc_chan_out_t [1:0] chan_o
);
	// ----------
	// helpers
	// ----------
	wire       wr  = cmd_valid_i && cmd_write_i;        // write taken
	wire [7:0] d   = cmd_data_i[7:0];                   // byte data
	wire       rsc = wr && cmd_code_i == CMD_BUS_RESET
		&& cmd_nbytes_i == NB_SEND;                      // bus reset
	wire       on  = chan_o[0].run || chan_o[1].run;     // any on
	wire       st0 = chan_o[0].run && !chan_o[0].ramping; // steady on
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----------
	// assertions
	// ----------
	a_onoff_bad_code: assert property (
		wr && cmd_code_i == CMD_ONOFF_CFG
		&& !(d inside {8'h1F, 8'h1E, 8'h17, 8'h16})
		|=> resp_ack_o && cml_fault_o) else $error("bad config code kept");
	a_opmode_bad_code: assert property (
		wr && cmd_code_i == CMD_OPER_MODE
		&& !(d inside {8'hA8, 8'h98, 8'h80, 8'h40, 8'h00})
		|=> resp_ack_o && cml_fault_o) else $error("bad mode code kept");
	a_fault_sticky: assert property (
		cml_fault_o && !rsc |=> cml_fault_o) else $error("fault lost");
	a_busy_refused: assert property (
		wr && (cmd_code_i == CMD_PHASE_CFG || cmd_code_i == CMD_SW_FREQ)
		&& on ##1 on |-> resp_valid_o && !resp_ack_o && busy_fault_o)
		else $error("busy write not refused");
	a_reset_all_off: assert property (
		$rose(rstn_i) |-> (!on)[*3]) else $error("on after reset");
	a_servo_steady: assert property (
		chan_o[0].servo_en |-> st0) else $error("servo while not steady");
	a_setpoint_slope: assert property (
		st0 && $past(st0) && $changed(chan_o[0].setpoint)
		|=> ($stable(chan_o[0].setpoint) || !chan_o[0].run)[*8])
		else $error("set point stepped");
	a_bus_reset_clear: assert property (
		rsc |=> resp_ack_o && !cml_fault_o && !busy_fault_o)
		else $error("faults not cleared");
	a_bus_reset_off: assert property (
		rsc |-> ##[1:4] !on) else $error("channels not stopped");
	// main scenarios reached
	c_bus_reset: cover property (rsc);
	c_busy_write: cover property (wr && cmd_code_i == CMD_PHASE_CFG && on);
	c_servo: cover property (chan_o[0].servo_en);
endmodule
bind popc_top popc_top_asserts popc_top_asserts_i (.clk_i, .rstn_i,
	.cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_nbytes_i, .cmd_data_i,
	.resp_valid_o, .resp_ack_o, .cml_fault_o, .busy_fault_o, .chan_o);

// ---- popc_host.sv ----
// host model: bus command master and run pin drivers
`timescale 1ns/1ps
module popc_host
	import popc_pkg::*;
(
	input  wire logic        clk_i,
	output logic             cmd_valid_o,
	output logic             cmd_write_o,
	output logic [7:0]       cmd_code_o,
	output logic [1:0]       cmd_nbytes_o,
	output logic [15:0]      cmd_data_o,
	output logic [1:0]       pin_o,
	input  wire logic        resp_ack_i,
	input  wire logic [15:0] resp_data_i
);
	logic [15:0] rdata; // last answer data
	logic        rack;  // last answer ack
	// idle bus at time zero
	initial begin
		{cmd_valid_o, cmd_write_o, cmd_code_o, cmd_nbytes_o} = '0;
		cmd_data_o = 16'h0000;
		pin_o = 2'b00;
	end
	// one command; converter mode bit 2 is never written here
	task automatic cmd(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_write_o = w;
		cmd_code_o = c;
		cmd_nbytes_o = !w || c == CMD_BUS_RESET ? NB_SEND :
			(c == CMD_SW_FREQ ? NB_WORD : NB_BYTE);
		cmd_data_o = d;
		@(negedge clk_i);
		rack = resp_ack_i;
		rdata = resp_data_i;
		cmd_valid_o = 1'b0;
		cmd_data_o = ~d; // released data does not hold
	endtask
	// run pin levels, changed off the sampling edge
	task automatic pins(input logic [1:0] v);
		@(negedge clk_i);
		pin_o = v;
	endtask
endmodule

// ---- tb_top.sv ----
// bench: host model drives the block, results judged here
`timescale 1ns/1ps
module tb_top;
	import popc_pkg::*;
	logic clk_i = 1'b0;  // 40 MHz clock
	logic rstn_i = 1'b0; // active low reset
	wire cv, cw, ra, cml, busy;
	wire [7:0] cc, ph;
	wire [1:0] cn, pin;
	wire [15:0] cd, rd_d, fq;
	popc_chan_out_t [1:0] ch; // channel outputs
	int fails = 0;
	int checks_done = 0;
	wire popc_nvm_t nvm = {{2{RST_ONOFF_CFG, RST_OPER_MODE, RST_CONV_MODE,
		RST_LOOP_COMP}}, RST_PHASE_CFG, RST_SW_FREQ}; // stored image
	always #12.5 clk_i = ~clk_i;
	popc_top popc_top_i (.clk_i(clk_i), .rstn_i(rstn_i),
		.channel_enable_pin_i(pin), .nvm_i(nvm), .cmd_valid_i(cv),
		.cmd_write_i(cw), .cmd_code_i(cc), .cmd_nbytes_i(cn),
		.cmd_data_i(cd), .resp_valid_o(), .resp_ack_o(ra),
		.resp_data_o(rd_d), .cml_fault_o(cml), .busy_fault_o(busy),
		.chan_o(ch), .phase_cfg_o(ph), .sw_freq_o(fq));
	popc_host popc_host_i (.clk_i(clk_i), .cmd_valid_o(cv),
		.cmd_write_o(cw), .cmd_code_o(cc), .cmd_nbytes_o(cn),
		.cmd_data_o(cd), .pin_o(pin), .resp_ack_i(ra), .resp_data_i(rd_d));
	// compare and count
	task automatic ck(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		popc_host_i.cmd(1'b1, c, d);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		popc_host_i.cmd(1'b0, c, 16'h0000);
		ck(popc_host_i.rdata, e);
	endtask
	// wait n falling edges
	task automatic cy(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// wait a bounded time for channel 0 run level, then judge it
	task automatic wt(input logic v, input int n);
		for (int i = 0; i < n && ch[0].run !== v; i++) @(negedge clk_i);
		ck(16'(ch[0].run), 16'(v));
	endtask
	task automatic t_reset;
		logic [7:0] c [6] = '{CMD_OPER_MODE, CMD_ONOFF_CFG, CMD_CONV_MODE,
			CMD_LOOP_COMP, CMD_PHASE_CFG, CMD_SW_FREQ};
		logic [15:0] e [6] = '{16'h0040, 16'h001E, 16'h00C7, 16'h00AE,
			16'h0010, 16'hFB52};
		for (int i = 0; i < 6; i++) rd(c[i], e[i]);
		ck(16'({ch[1].gm, ch[1].compensation_resistor, ch[0].gm, ch[0].compensation_resistor}),
			16'hAEAE);
		ck(16'({ch[0].ilim_high, ch[0].temp_direct, ch[0].low_dcr,
			ch[0].vrange_low}), 16'h000B);
		ck(fq, 16'hFB52);
		ck(16'(ph), 16'h10);
	endtask
	task automatic t_codes;
		logic [7:0] o [4] = '{8'h1F, 8'h1E, 8'h17, 8'h16};
		foreach (o[i]) begin
			wr(CMD_ONOFF_CFG, 16'(o[i]));
			rd(CMD_ONOFF_CFG, 16'(o[i]));
		end
		ck(16'(cml), 16'h0000);
		wr(CMD_ONOFF_CFG, 16'h0015);
		rd(CMD_ONOFF_CFG, 16'h0016);
		wr(CMD_OPER_MODE, 16'h0055);
		rd(CMD_OPER_MODE, 16'h0040);
		ck(16'(cml), 16'h0001);
		wr(CMD_BUS_RESET, 16'h0000);
		ck(16'({popc_host_i.rack, cml}), 16'h0002);
		rd(CMD_ONOFF_CFG, 16'h001E);
	endtask
	task automatic t_run;
		wr(CMD_ONOFF_CFG, 16'h1F);
		wr(CMD_OPER_MODE, 16'h80);
		cy(10);
		wt(1'b0, 0);
		popc_host_i.pins(2'b01);
		wt(1'b1, 10);
		ck(16'(ch[0].fccm), 16'h0);
		for (int i = 0; i < 300 && ch[0].ramping !== 1'b0; i++)
			@(negedge clk_i);
		ck(16'({ch[0].setpoint, ch[0].fccm, ch[0].servo_en}),
			16'h203);
		wr(CMD_OPER_MODE, 16'hA8);
		cy(40);
		ck(16'(ch[0].setpoint inside {[8'h81:8'h87]}), 16'h1);
		cy(60);
		ck(16'(ch[0].setpoint), 16'h88);
		wr(CMD_PHASE_CFG, 16'h11);
		ck(16'({popc_host_i.rack, busy}), 16'h1);
		rd(CMD_PHASE_CFG, 16'h10);
		wr(CMD_OPER_MODE, 16'h98);
		cy(200);
		ck(16'(ch[0].setpoint), 16'h78);
		wr(CMD_OPER_MODE, 16'h40);
		cy(40);
		wt(1'b1, 0);
		wt(1'b0, 300);
		wr(CMD_OPER_MODE, 16'h80);
		wt(1'b1, 10);
		wr(CMD_OPER_MODE, 16'h0);
		wt(1'b0, 4);
	endtask
	task automatic t_pin;
		wr(CMD_BUS_RESET, 16'h0);
		ck(16'(busy), 16'h0);
		cy(10);
		wt(1'b0, 0);
		wr(CMD_ONOFF_CFG, 16'h17);
		wt(1'b1, 10);
		wr(CMD_OPER_MODE, 16'h0);
		cy(10);
		wt(1'b1, 0);
		popc_host_i.pins(2'b00);
		wt(1'b0, 6);
		wr(CMD_ONOFF_CFG, 16'h16);
		popc_host_i.pins(2'b01);
		wt(1'b1, 10);
		cy(210); // soft-start over, pin low now starts the off sequence
		popc_host_i.pins(2'b00);
		cy(60);
		wt(1'b1, 0);
		wt(1'b0, 300);
	endtask
	// verdict and end of run
	task automatic results;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		cy(3);
		rstn_i = 1'b1;
		cy(2);
		t_reset();
		t_codes();
		t_run();
		t_pin();
		results();
	end
	// watchdog: about four times the expected run
	initial begin
		repeat (6000) @(posedge clk_i);
		fails++;
		results();
	end
endmodule
